// [rtl/fspc_pkg.sv]
// Package with the constants and types of the flash self-program controller.
package fspc_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  // The printed offset is not a multiple of four, so it is a word index.
  localparam logic [11:0] CSR_INDEX = 12'h037;
  localparam logic [11:0] CSR_ADDR = {CSR_INDEX[9:0], 2'b00};
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam int IRQ_EN_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int RES_BIT = 5;
  localparam int REEN_BIT = 4;
  localparam int LOCK_BIT = 3;
  localparam int PROG_BIT = 2;
  localparam int CLEAR_BIT = 1;
  localparam int EN_BIT = 0;

  // ********************************************************************
  // Command patterns of the low five bits
  // ********************************************************************
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_PROGRAM = 5'h05;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam logic [2:0] SPM_WINDOW_CYC = 3'h4;
  localparam logic [2:0] LPM_WINDOW_CYC = 3'h3;
  localparam logic [15:0] OP_CYCLES = 16'h0050;

  // ********************************************************************
  // Flash geometry
  // ********************************************************************
  localparam int PC_WIDTH = 14;
  localparam int WORD_BITS = 6;
  localparam int PAGE_BITS = 8;
  localparam int BUF_WORDS = 64;
  localparam logic [7:0] RWW_PAGES = 8'hE0;
  localparam logic [13:0] NO_READ_WHILE_WRITE_REGION_START = 14'h3800;
  localparam logic [13:0] FLASH_LAST = 14'h3FFF;
  localparam logic [13:0] BOOT_START_256 = 14'h3F00;
  localparam logic [13:0] BOOT_START_512 = 14'h3E00;
  localparam logic [13:0] BOOT_START_1K = 14'h3C00;
  localparam logic [13:0] BOOT_START_2K = 14'h3800;
  localparam logic [7:0] LOCK_RESET = 8'hFF;

  typedef enum logic [1:0] {FSPC_IDLE, FSPC_ARMED, FSPC_BUSY} fspc_state_t;

endpackage : fspc_pkg

// [rtl/fspc_page_buf.sv]
// Temporary page buffer: one write port and a registered read port.
`timescale 1ns/1ps
module fspc_page_buf (
  input wire logic clk,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [5:0] raddr,
  output logic [15:0] rdata_r
);

  logic [15:0] mem [0:fspc_pkg::BUF_WORDS-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // No reset on the array; validity is tracked by the controller.
  always_ff @(posedge clk) begin
    rdata_r <= mem[raddr];
  end

endmodule : fspc_page_buf

// [rtl/fspc_ctrl.sv]
// Flash self-program controller with its control/status register on APB.
// Operation
// - boot size selects boot start, ends 0x3FFF
// - READ_WHILE_WRITE_REGION below 0x3800, NO_READ_WHILE_WRITE_REGION from 0x3800
// - 14-bit counter, bits 5:0 pick word
// - page from pointer 14:7, bit 15 ignored
// - buffer word from pointer 6:1
// - ready interrupt while enable bit clear
// - READ_WHILE_WRITE_REGION operation sets busy, blocks region
// - busy clears on re-enable or buffer load
// - re-enable armed, ignored while operation busy
// - re-enable write aborts fill, discards data
// - lock command writes lock bits from low data
// - lock command self-clears done or timeout
// - load within three cycles reads lock/fuse
// - page program writes buffer to page
// - page program self-clears done or timeout
// - CPU stalled during NO_READ_WHILE_WRITE_REGION erase/program
// - page clear erases page, self-clears
// - plain enable loads word into buffer
// - enable opens four-cycle window, holds busy
// - only five low patterns take effect
`timescale 1ns/1ps
module fspc_ctrl (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SPM_REQ,
  input wire logic LPM_REQ,
  input wire logic [15:0] Z_PTR,
  input wire logic [7:0] LOW_DATA,
  input wire logic [7:0] HIGH_DATA,
  input wire logic GIE,
  input wire logic [1:0] BOOT_SIZE,
  input wire logic [7:0] FUSE_BITS,
  input wire logic [13:0] READ_ADDR,
  input wire logic [5:0] BUF_RADDR,
  output logic [15:0] BUF_RDATA,
  output logic BUF_RVALID,
  output logic READY_IRQ,
  output logic CPU_STALL,
  output logic RWW_BUSY,
  output logic READ_DENIED,
  output logic FLASH_ERASE,
  output logic FLASH_PROGRAM,
  output logic FLASH_BUSY,
  output logic [7:0] FLASH_PAGE,
  output logic LOCK_WRITE,
  output logic [7:0] LOCK_BITS,
  output logic [7:0] LPM_DATA,
  output logic LPM_VALID,
  output logic [13:0] BOOT_START,
  output logic [13:0] APP_END
);

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  function automatic logic page_in_rww(input logic [7:0] page);
    page_in_rww = (page < fspc_pkg::RWW_PAGES);
  endfunction : page_in_rww

  function automatic logic legal_cmd(input logic [4:0] low);
    legal_cmd = (low == fspc_pkg::CMD_REENABLE) || (low == fspc_pkg::CMD_LOCK) ||
      (low == fspc_pkg::CMD_PROGRAM) || (low == fspc_pkg::CMD_LOAD) ||
      (low == fspc_pkg::CMD_ERASE);
  endfunction : legal_cmd

  fspc_pkg::fspc_state_t state_r;
  logic [4:0] low_r;
  logic irq_en_r;
  logic busy_r;
  logic [2:0] cyc_r;
  logic [15:0] op_cnt_r;
  logic op_no_read_while_write_region_r;
  logic pready_r;
  logic [fspc_pkg::BUF_WORDS-1:0] fill_valid_r;
  logic [7:0] lock_r;
  logic [7:0] csr_value;
  logic hit;
  logic wr_fire;
  logic wr_cmd_ok;
  logic spm_take;
  logic op_start;
  logic op_done;
  logic load_take;
  logic reen_take;
  logic lock_take;
  logic fill_abort;
  logic [7:0] z_page;
  logic [5:0] z_word;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  // ********************************************************************
  // APB slave
  // ********************************************************************
  assign hit = (PADDR == fspc_pkg::CSR_ADDR);
  assign wr_fire = PSEL && PENABLE && PWRITE && pready_r && hit;
  assign csr_value = {irq_en_r, busy_r, 1'b0, low_r};

  // One wait state keeps PREADY and PRDATA straight from flip-flops.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_r <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      pready_r <= PSEL && PENABLE && !pready_r;
      PSLVERR <= PSEL && PENABLE && !pready_r && !hit;
      if (PSEL && PENABLE && !pready_r && !PWRITE) begin
        PRDATA <= hit ? {24'h00_0000, csr_value} : 32'h0000_0000;
      end
    end
  end
  assign PREADY = pready_r;

  reserved_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0 && !PRDATA[5])
    else $error("Reserved register bits read nonzero.");

  // ********************************************************************
  // Command sequencer
  // ********************************************************************
  assign z_page = Z_PTR[14:7];
  assign z_word = Z_PTR[6:1];
  assign wr_cmd_ok = wr_fire && (state_r != fspc_pkg::FSPC_BUSY) &&
    legal_cmd(PWDATA[4:0]);
  assign spm_take = (state_r == fspc_pkg::FSPC_ARMED) && SPM_REQ && !wr_cmd_ok;
  assign op_start = spm_take && (low_r[fspc_pkg::CLEAR_BIT] || low_r[fspc_pkg::PROG_BIT]);
  assign load_take = spm_take && (low_r == fspc_pkg::CMD_LOAD);
  assign reen_take = spm_take && low_r[fspc_pkg::REEN_BIT];
  assign lock_take = spm_take && low_r[fspc_pkg::LOCK_BIT];
  assign op_done = (state_r == fspc_pkg::FSPC_BUSY) && (op_cnt_r == 16'h0000);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= fspc_pkg::FSPC_IDLE;
      low_r <= fspc_pkg::CSR_RESET[4:0];
      cyc_r <= 3'h0;
      op_cnt_r <= 16'h0000;
    end else begin
      case (state_r)
        fspc_pkg::FSPC_IDLE: begin
          if (wr_cmd_ok) begin
            state_r <= fspc_pkg::FSPC_ARMED;
            low_r <= PWDATA[4:0];
            cyc_r <= 3'h0;
          end
        end
        fspc_pkg::FSPC_ARMED: begin
          if (wr_cmd_ok) begin
            low_r <= PWDATA[4:0];
            cyc_r <= 3'h0;
          end else if (op_start) begin
            state_r <= fspc_pkg::FSPC_BUSY;
            op_cnt_r <= fspc_pkg::OP_CYCLES - 16'h0001;
          end else if (spm_take || (cyc_r == fspc_pkg::SPM_WINDOW_CYC - 3'h1)) begin
            state_r <= fspc_pkg::FSPC_IDLE;
            low_r <= 5'h00;
          end else begin
            cyc_r <= cyc_r + 3'h1;
          end
        end
        fspc_pkg::FSPC_BUSY: begin
          if (op_done) begin
            state_r <= fspc_pkg::FSPC_IDLE;
            low_r <= 5'h00;
          end else begin
            op_cnt_r <= op_cnt_r - 16'h0001;
          end
        end
        default: begin
          state_r <= fspc_pkg::FSPC_IDLE;
          low_r <= 5'h00;
        end
      endcase
    end
  end

  window_timeout_a: assert property ((state_r == fspc_pkg::FSPC_ARMED) && !SPM_REQ &&
      !wr_cmd_ok && (cyc_r == 3'h3) |=> (low_r == 5'h00) && (state_r == fspc_pkg::FSPC_IDLE))
    else $error("Armed command outlived its four-cycle window.");
  enable_hold_a: assert property (op_start |=> low_r[fspc_pkg::EN_BIT] [*8])
    else $error("Enable bit dropped during a running operation.");
  ignore_bad_a: assert property (wr_fire && (state_r == fspc_pkg::FSPC_IDLE) &&
      !legal_cmd(PWDATA[4:0]) |=> $stable(low_r) && (state_r == fspc_pkg::FSPC_IDLE))
    else $error("Illegal command pattern took effect.");
  busy_locked_a: assert property ((state_r == fspc_pkg::FSPC_BUSY) && !op_done |=>
      $stable(low_r))
    else $error("Command bits changed while an operation ran.");

  // ********************************************************************
  // Status bits and interrupt
  // ********************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_en_r <= fspc_pkg::CSR_RESET[fspc_pkg::IRQ_EN_BIT];
    end else if (wr_fire) begin
      irq_en_r <= PWDATA[fspc_pkg::IRQ_EN_BIT];
    end
  end

  // The busy flag is set only by an operation start, which cannot share a cycle with a clear.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_r <= fspc_pkg::CSR_RESET[fspc_pkg::BUSY_BIT];
    end else if (op_start && page_in_rww(z_page)) begin
      busy_r <= 1'b1;
    end else if (reen_take || load_take) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      READY_IRQ <= 1'b0;
      RWW_BUSY <= 1'b0;
      READ_DENIED <= 1'b0;
    end else begin
      READY_IRQ <= irq_en_r && GIE && !low_r[fspc_pkg::EN_BIT];
      RWW_BUSY <= busy_r;
      READ_DENIED <= busy_r && (READ_ADDR < fspc_pkg::NO_READ_WHILE_WRITE_REGION_START);
    end
  end

  irq_level_a: assert property (irq_en_r && GIE && !low_r[fspc_pkg::EN_BIT] |=> READY_IRQ)
    else $error("Ready interrupt not requested while idle.");
  busy_set_a: assert property (op_start && page_in_rww(z_page) |=> busy_r ##1 RWW_BUSY)
    else $error("READ_WHILE_WRITE_REGION operation did not raise the busy flag.");
  load_clear_a: assert property (load_take |=> !busy_r)
    else $error("Buffer load left the busy flag set.");

  // ********************************************************************
  // Flash operation outputs
  // ********************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FLASH_ERASE <= 1'b0;
      FLASH_PROGRAM <= 1'b0;
      FLASH_BUSY <= 1'b0;
      FLASH_PAGE <= 8'h00;
      op_no_read_while_write_region_r <= 1'b0;
      CPU_STALL <= 1'b0;
    end else begin
      FLASH_ERASE <= op_start && low_r[fspc_pkg::CLEAR_BIT];
      FLASH_PROGRAM <= op_start && low_r[fspc_pkg::PROG_BIT];
      FLASH_BUSY <= op_start || ((state_r == fspc_pkg::FSPC_BUSY) && !op_done);
      if (op_start) begin
        FLASH_PAGE <= z_page;
        op_no_read_while_write_region_r <= !page_in_rww(z_page);
      end
      CPU_STALL <= (op_start && !page_in_rww(z_page)) ||
        ((state_r == fspc_pkg::FSPC_BUSY) && !op_done && op_no_read_while_write_region_r);
    end
  end

  stall_no_read_while_write_region_a: assert property (op_start && !page_in_rww(z_page) |=> CPU_STALL [*8])
    else $error("CPU not stalled during an NO_READ_WHILE_WRITE_REGION operation.");

  // ********************************************************************
  // Temporary page buffer
  // ********************************************************************
  assign fill_abort = wr_cmd_ok && (PWDATA[4:0] == fspc_pkg::CMD_REENABLE) &&
    (|fill_valid_r);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fill_valid_r <= '0;
    end else if (fill_abort || (op_done && low_r[fspc_pkg::PROG_BIT])) begin
      fill_valid_r <= '0;
    end else if (load_take) begin
      fill_valid_r[z_word] <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUF_RVALID <= 1'b0;
    end else begin
      BUF_RVALID <= fill_valid_r[BUF_RADDR];
    end
  end

  fspc_page_buf u_page_buf (
    .clk(CLK),
    .we(load_take),
    .waddr(z_word),
    .wdata({HIGH_DATA, LOW_DATA}),
    .raddr(BUF_RADDR),
    .rdata_r(BUF_RDATA)
  );

  fill_abort_a: assert property (fill_abort |=> fill_valid_r == '0)
    else $error("Re-enable write did not discard the buffer.");

  // ********************************************************************
  // Lock bits and readback
  // ********************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lock_r <= fspc_pkg::LOCK_RESET;
      LOCK_WRITE <= 1'b0;
      LPM_DATA <= 8'h00;
      LPM_VALID <= 1'b0;
    end else begin
      LOCK_WRITE <= lock_take;
      if (lock_take) begin
        lock_r <= LOW_DATA;
      end
      LPM_VALID <= 1'b0;
      if (LPM_REQ && (state_r == fspc_pkg::FSPC_ARMED) && low_r[fspc_pkg::LOCK_BIT] &&
          (cyc_r < fspc_pkg::LPM_WINDOW_CYC)) begin
        LPM_DATA <= Z_PTR[0] ? lock_r : FUSE_BITS;
        LPM_VALID <= 1'b1;
      end
    end
  end
  assign LOCK_BITS = lock_r;

  lock_write_a: assert property (lock_take |=> (LOCK_BITS == $past(LOW_DATA)) && LOCK_WRITE)
    else $error("Lock bits not taken from low data.");

  // ********************************************************************
  // Boot section bounds
  // ********************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BOOT_START <= fspc_pkg::BOOT_START_2K;
      APP_END <= fspc_pkg::BOOT_START_2K - 14'h0001;
    end else begin
      case (BOOT_SIZE)
        2'h3: BOOT_START <= fspc_pkg::BOOT_START_256;
        2'h2: BOOT_START <= fspc_pkg::BOOT_START_512;
        2'h1: BOOT_START <= fspc_pkg::BOOT_START_1K;
        default: BOOT_START <= fspc_pkg::BOOT_START_2K;
      endcase
      case (BOOT_SIZE)
        2'h3: APP_END <= fspc_pkg::BOOT_START_256 - 14'h0001;
        2'h2: APP_END <= fspc_pkg::BOOT_START_512 - 14'h0001;
        2'h1: APP_END <= fspc_pkg::BOOT_START_1K - 14'h0001;
        default: APP_END <= fspc_pkg::BOOT_START_2K - 14'h0001;
      endcase
    end
  end

  boot_bound_a: assert property ((BOOT_SIZE == 2'h3) [*2] |->
      (BOOT_START == 14'h3F00) && (APP_END == 14'h3EFF) && (fspc_pkg::FLASH_LAST == 14'h3FFF))
    else $error("Boot section bounds wrong for the smallest size.");

endmodule : fspc_ctrl

// [sim/fspc_cpu_model.sv]
// CPU core model issuing store-program and load-program requests.
`timescale 1ns/1ps
module fspc_cpu_model (
  input wire logic clk,
  input wire logic stall,
  output logic spm_req,
  output logic lpm_req,
  output logic [15:0] z_ptr,
  output logic [7:0] low_data,
  output logic [7:0] high_data
);
  logic drv;
  initial begin
    drv = 1'b0;
    spm_req = 1'b0;
    lpm_req = 1'b0;
    z_ptr = 16'h0000;
    low_data = 8'h00;
    high_data = 8'h00;
  end
  // Idle operands keep changing, so a stale value can never pass for a live one.
  always @(posedge clk) begin
    if (!drv) begin
      z_ptr <= ~z_ptr;
      low_data <= ~low_data;
      high_data <= ~high_data;
    end
  end
  task automatic req(input logic load_program_instruction, input logic [15:0] z, input logic [7:0] lo,
                     input logic [7:0] hi);
    while (stall === 1'b1) begin
      @(posedge clk);
    end
    drv = 1'b1;
    @(posedge clk);
    spm_req <= !load_program_instruction;
    lpm_req <= load_program_instruction;
    z_ptr <= z;
    low_data <= lo;
    high_data <= hi;
    @(posedge clk);
    spm_req <= 1'b0;
    lpm_req <= 1'b0;
    drv = 1'b0;
  endtask : req
endmodule : fspc_cpu_model

// [sim/testbench.sv]
// Self-checking testbench of the flash self-program controller.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: %h, want %h", $time, (a), (b)); end end
module testbench;
  localparam logic [11:0] CSR_A = fspc_pkg::CSR_ADDR;
  localparam logic [13:0] BST [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
  logic CLK, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, GIE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [1:0] BOOT_SIZE = 2'h0;
  logic [7:0] FUSE_BITS = 8'h00, FLASH_PAGE, LOCK_BITS, LPM_DATA, LOW_DATA, HIGH_DATA;
  logic [13:0] READ_ADDR = 14'h0000, BOOT_START, APP_END;
  logic [5:0] BUF_RADDR = 6'h00;
  logic [15:0] BUF_RDATA, Z_PTR;
  logic PREADY, PSLVERR, BUF_RVALID, READY_IRQ, CPU_STALL, RWW_BUSY, READ_DENIED;
  logic FLASH_ERASE, FLASH_PROGRAM, FLASH_BUSY, LOCK_WRITE, LPM_VALID, SPM_REQ, LPM_REQ;
  int failures = 0, check_count = 0, cycles = 0;
  logic [32:0] rd_q [$];
  logic [9:0] op_q [$];
  logic [7:0] lpm_q [$], lock_q [$];
  logic [9:0] op_e;
  logic [7:0] lk_e;
  logic op_p = 1'b0, lk_p = 1'b0;

  fspc_ctrl u_fspc_ctrl (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SPM_REQ(SPM_REQ), .LPM_REQ(LPM_REQ), .Z_PTR(Z_PTR),
    .LOW_DATA(LOW_DATA), .HIGH_DATA(HIGH_DATA), .GIE(GIE), .BOOT_SIZE(BOOT_SIZE),
    .FUSE_BITS(FUSE_BITS), .READ_ADDR(READ_ADDR), .BUF_RADDR(BUF_RADDR),
    .BUF_RDATA(BUF_RDATA), .BUF_RVALID(BUF_RVALID), .READY_IRQ(READY_IRQ),
    .CPU_STALL(CPU_STALL), .RWW_BUSY(RWW_BUSY), .READ_DENIED(READ_DENIED),
    .FLASH_ERASE(FLASH_ERASE), .FLASH_PROGRAM(FLASH_PROGRAM), .FLASH_BUSY(FLASH_BUSY),
    .FLASH_PAGE(FLASH_PAGE), .LOCK_WRITE(LOCK_WRITE), .LOCK_BITS(LOCK_BITS),
    .LPM_DATA(LPM_DATA), .LPM_VALID(LPM_VALID), .BOOT_START(BOOT_START), .APP_END(APP_END));
  fspc_cpu_model u_fspc_cpu_model (.clk(CLK), .stall(CPU_STALL), .spm_req(SPM_REQ),
    .lpm_req(LPM_REQ), .z_ptr(Z_PTR), .low_data(LOW_DATA), .high_data(HIGH_DATA));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge CLK) begin : mon
    logic [32:0] e;
    if (op_p) begin
      `CHK(FLASH_PAGE, op_e[7:0])
      `CHK(CPU_STALL, op_e[8])
    end
    if (lk_p) `CHK(LOCK_BITS, lk_e)
    op_p = 1'b0;
    lk_p = 1'b0;
    if (PSEL && PENABLE && PREADY) begin
      `CHK(rd_q.size() > 0, 1'b1)
      e = rd_q.pop_front();
      `CHK(PSLVERR, e[32])
      if (!PWRITE) `CHK(PRDATA, {24'h0, e[7:0]})
    end
    if (FLASH_ERASE || FLASH_PROGRAM) begin
      `CHK(op_q.size() > 0, 1'b1)
      op_e = op_q.pop_front();
      `CHK(FLASH_PROGRAM, op_e[9])
      op_p = 1'b1;
    end
    if (LOCK_WRITE) begin
      `CHK(lock_q.size() > 0, 1'b1)
      lk_e = lock_q.pop_front();
      lk_p = 1'b1;
    end
    if (LPM_VALID) begin
      `CHK(lpm_q.size() > 0, 1'b1)
      e = {25'h0, lpm_q.pop_front()};
      `CHK(LPM_DATA, e[7:0])
    end
  end

  // ****************************************
  // Bus master and stimulus
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic err);
    logic [31:0] t;
    t = $urandom;
    rd_q.push_back({err, 24'h0, d});
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {t[23:0], d};
    PENABLE <= 1'b0;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wait_op;
    int n;
    n = 0;
    while (FLASH_BUSY !== 1'b0 && n < 200) begin
      @(posedge CLK);
      n++;
    end
    `CHK(FLASH_BUSY, 1'b0)
  endtask : wait_op

  initial begin
    logic [7:0] pg, lk;
    logic [5:0] w;
    logic [15:0] d;
    logic [4:0] v;
    void'($urandom(74));
    repeat (6) @(posedge CLK);
    ARST_N <= 1'b1;
    `CHK(LOCK_BITS, fspc_pkg::LOCK_RESET)
    apb(0, CSR_A, 8'h00, 0);
    apb(0, 12'h037, 8'h00, 1);
    apb(1, 12'h0E0, 8'h81, 1);
    apb(1, CSR_A, 8'hFF, 0);
    apb(0, CSR_A, 8'h80, 0);
    GIE <= 1'b1;
    repeat (2) @(posedge CLK);
    @(negedge CLK) `CHK(READY_IRQ, 1'b1)
    apb(1, CSR_A, 8'h81, 0);
    @(posedge CLK);
    @(negedge CLK) `CHK(READY_IRQ, 1'b0)
    repeat (6) @(posedge CLK);
    @(negedge CLK) `CHK(READY_IRQ, 1'b1)
    apb(1, CSR_A, 8'h00, 0);
    for (int b = 0; b < 4; b++) begin
      BOOT_SIZE <= 2'(b);
      repeat (2) @(posedge CLK);
      @(negedge CLK) `CHK(BOOT_START, BST[b])
      `CHK(APP_END, BST[b] - 14'h0001)
    end
    for (int i = 0; i < 6; i++) begin
      v = 5'($urandom);
      while (v inside {5'h11, 5'h09, 5'h05, 5'h01, 5'h03}) v = 5'($urandom);
      apb(1, CSR_A, {3'h0, v}, 0);
      apb(0, CSR_A, 8'h00, 0);
    end
    for (int i = 0; i < 3; i++) begin
      w = 6'($urandom);
      d = 16'($urandom);
      apb(1, CSR_A, {3'h0, fspc_pkg::CMD_LOAD}, 0);
      u_fspc_cpu_model.req(0, {1'b1, 8'($urandom), w, 1'b0}, d[7:0], d[15:8]);
      BUF_RADDR <= w;
      repeat (2) @(posedge CLK);
      @(negedge CLK) `CHK(BUF_RDATA, d)
      `CHK(BUF_RVALID, 1'b1)
      apb(0, CSR_A, 8'h00, 0);
    end
    apb(1, CSR_A, {3'h0, fspc_pkg::CMD_PROGRAM}, 0);
    op_q.push_back({2'b11, 8'hE0});
    u_fspc_cpu_model.req(0, 16'h7000, 8'($urandom), 8'($urandom));
    repeat (3) @(posedge CLK);
    @(negedge CLK) `CHK(RWW_BUSY, 1'b0)
    wait_op();
    apb(0, CSR_A, 8'h00, 0);
    `CHK(BUF_RVALID, 1'b0)
    for (int k = 0; k < 2; k++) begin
      pg = k ? 8'($urandom % 224) : 8'hDF;
      w = 6'($urandom);
      READ_ADDR <= 14'($urandom % 14336);
      apb(1, CSR_A, k ? 8'h05 : 8'h03, 0);
      op_q.push_back({k[0], 1'b0, pg});
      u_fspc_cpu_model.req(0, {1'b1, pg, k ? 6'h00 : w, 1'b0}, 8'h00, 8'h00);
      repeat (3) @(posedge CLK);
      @(negedge CLK) `CHK(RWW_BUSY, 1'b1)
      `CHK(READ_DENIED, 1'b1)
      @(posedge CLK) READ_ADDR <= 14'h3800;
      repeat (2) @(posedge CLK);
      @(negedge CLK) `CHK(READ_DENIED, 1'b0)
      apb(0, CSR_A, k ? 8'h45 : 8'h43, 0);
      apb(1, CSR_A, 8'h11, 0);
      apb(0, CSR_A, k ? 8'h45 : 8'h43, 0);
      wait_op();
      apb(0, CSR_A, 8'h40, 0);
      apb(1, CSR_A, k ? 8'h01 : 8'h11, 0);
      u_fspc_cpu_model.req(0, {1'b0, 8'($urandom), w, 1'b0}, 8'h3C, 8'hA5);
      apb(0, CSR_A, 8'h00, 0);
      @(negedge CLK) `CHK(RWW_BUSY, 1'b0)
    end
    BUF_RADDR <= w;
    repeat (2) @(posedge CLK);
    @(negedge CLK) `CHK(BUF_RVALID, 1'b1)
    `CHK(BUF_RDATA, 16'hA53C)
    apb(1, CSR_A, 8'h11, 0);
    repeat (2) @(posedge CLK);
    @(negedge CLK) `CHK(BUF_RVALID, 1'b0)
    lk = 8'($urandom);
    apb(1, CSR_A, {3'h0, fspc_pkg::CMD_LOCK}, 0);
    lock_q.push_back(lk);
    u_fspc_cpu_model.req(0, {15'($urandom), 1'b0}, lk, 8'($urandom));
    apb(0, CSR_A, 8'h00, 0);
    for (int z = 0; z < 2; z++) begin
      FUSE_BITS <= 8'($urandom);
      @(posedge CLK);
      apb(1, CSR_A, {3'h0, fspc_pkg::CMD_LOCK}, 0);
      lpm_q.push_back(z ? lk : FUSE_BITS);
      u_fspc_cpu_model.req(1, 16'(z), 8'h00, 8'h00);
      repeat (6) @(posedge CLK);
    end
    foreach (BST[c]) begin
      v = c == 0 ? fspc_pkg::CMD_LOCK : c == 1 ? fspc_pkg::CMD_PROGRAM : c == 2 ? 5'h03 : 5'h01;
      apb(1, CSR_A, {3'h0, v}, 0);
      repeat (6) @(posedge CLK);
      apb(0, CSR_A, 8'h00, 0);
      u_fspc_cpu_model.req(0, 16'h0000, 8'h00, 8'h00);
    end
    repeat (8) @(posedge CLK);
    `CHK(rd_q.size() + op_q.size() + lpm_q.size() + lock_q.size(), 0)
    stop_test();
  end
endmodule : testbench
